// ===== src/nsr_pkg.sv
// Constants for the network setup register bank
`default_nettype none
package nsr_pkg;
    // Register port addresses
    localparam logic [2:0] ADDR_PAGE   = 3'h5;
    localparam logic [2:0] ADDR_CONFIG = 3'h6;
    localparam logic [2:0] ADDR_PAGED  = 3'h7;
    // Page select codes
    localparam logic [2:0] PAGE_SETUP1 = 3'h2;
    localparam logic [2:0] PAGE_SETUP2 = 3'h4;
    localparam int         PAGE_TOP    = 2;
    // Reset values
    localparam logic [7:0] SETUP1_RST  = 8'h00;
    localparam logic [7:0] SETUP2_RST  = 8'h00;
    localparam logic [7:0] CONFIG_RST  = 8'h00;
    localparam logic [2:0] PAGE_RST    = 3'h0;
    // Setup one fields
    localparam int S1_PULSE_PP   = 7;
    localparam int S1_SHORT_LIM  = 6;
    localparam int S1_PROMISC    = 4;
    localparam int S1_CKP_LO     = 1;
    localparam int S1_HALF_ARB   = 0;
    // Setup two fields
    localparam int S2_FAST_READ  = 7;
    localparam int S2_ENHANCED   = 3;
    localparam int S2_IDLE_OFF   = 2;
    localparam int S2_RCN_LO     = 0;
    // Configuration fields
    localparam int CFG_SOFT_RST  = 7;
    // Refusal limits
    localparam logic [7:0] REFUSE_SHORT = 8'h04;
    localparam logic [7:0] REFUSE_LONG  = 8'h80;
    // Clock and rate
    localparam int          CLK_HZ      = 20_000_000;
    localparam logic [7:0]  DIV_FAST    = 8'h40;
    localparam logic [7:0]  DIV_SLOW    = 8'h80;
    localparam int          BASE_BPS    = 312_500;
    // Reconfiguration timeouts in microseconds at the base rate
    localparam longint T_RCN0_US = 6_720_000;
    localparam longint T_RCN1_US = 1_680_000;
    localparam longint T_RCN2_US = 840_000;
    localparam longint T_RCN3_US = 420_000;
    // Bit periods per timeout
    localparam int RCN0_BITS = int'(T_RCN0_US * BASE_BPS / 1_000_000);
    localparam int RCN1_BITS = int'(T_RCN1_US * BASE_BPS / 1_000_000);
    localparam int RCN2_BITS = int'(T_RCN2_US * BASE_BPS / 1_000_000);
    localparam int RCN3_BITS = int'(T_RCN3_US * BASE_BPS / 1_000_000);
endpackage
`default_nettype wire

// ===== src/nsr_tick_if.sv
// Tick carrier between the rate divider and the register bank
`timescale 1ns/1ps
`default_nettype none
interface nsr_tick_if;
    logic [2:0] rate_sel;
    logic       half_arb;
    logic       rate_tick;
    logic       arb_tick;
    modport gen (input rate_sel, half_arb, output rate_tick, arb_tick);
    modport use_ (output rate_sel, half_arb, input rate_tick, arb_tick);
endinterface
`default_nettype wire

// ===== src/nsr_rate_div.sv
// Bit rate and arbitration enable divider
`timescale 1ns/1ps
`default_nettype none
module nsr_rate_div
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Ticks
    nsr_tick_if.gen   tk
);
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic       rate_q;
    logic       arb_q;
    logic [7:0] div_w;
    logic       wrap_w;

    // Codes beyond the first clamp to the slowest rate the line supports
    function automatic logic [7:0] div_for(input logic [2:0] sel);
        div_for = (sel == 3'h0) ? nsr_pkg::DIV_FAST : nsr_pkg::DIV_SLOW;
    endfunction

    assign div_w  = div_for(tk.rate_sel);
    assign wrap_w = (cnt_q >= div_w - 8'h01);
    assign cnt_d  = wrap_w ? 8'h00 : cnt_q + 8'h01;
    assign tk.rate_tick = rate_q;
    assign tk.arb_tick  = arb_q;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cnt_q  <= 8'h00;
            rate_q <= 1'b0;
            arb_q  <= 1'b0;
        end
        else
        begin
            cnt_q  <= cnt_d;
            rate_q <= wrap_w;
            arb_q  <= tk.half_arb ? ~arb_q : 1'b1;
        end
    end

    chk_rate_gap: assert property (@(posedge clk) disable iff (rst)
        (rate_q && tk.rate_sel == 3'h0) |=> !rate_q [*8])
        else $error("rate tick spacing too short");
    chk_arb_half: assert property (@(posedge clk) disable iff (rst)
        (tk.half_arb && $past(tk.half_arb) && arb_q) |=> !arb_q)
        else $error("halved arbitration tick not halved");
endmodule
`default_nettype wire

// ===== src/nsr_setup_regs.sv
// Network setup register bank with its controlled functions
`timescale 1ns/1ps
`default_nettype none
module nsr_setup_regs
#(
    parameter int RCN0_BITS = nsr_pkg::RCN0_BITS,
    parameter int RCN1_BITS = nsr_pkg::RCN1_BITS,
    parameter int RCN2_BITS = nsr_pkg::RCN2_BITS,
    parameter int RCN3_BITS = nsr_pkg::RCN3_BITS
)
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Host register port
    input  wire logic [2:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr_stb,
    output logic      [7:0] rdata_q,
    // Line pulse driver
    input  wire logic       pulse_req,
    output logic            pulse_out_q,
    output logic            pulse_oe_n_q,
    // Refusal events
    input  wire logic       refusal_evt,
    input  wire logic       refusal_clr,
    output logic            excess_refusal_flag_q,
    // Receive filter
    input  wire logic       pkt_valid,
    input  wire logic [7:0] pkt_dest_id,
    input  wire logic [7:0] node_id,
    output logic            pkt_accept_q,
    output logic            pkt_ack_q,
    // Timing controls
    output logic            rate_tick_q,
    output logic            arb_tick_q,
    output logic            fast_read_q,
    output logic            enhanced_q,
    // RAM initialisation gate
    input  wire logic       line_idle,
    input  wire logic       init_wr_req,
    output logic            init_wr_ok_q,
    // Reconfiguration timer
    input  wire logic       reconfig_restart,
    output logic            reconfig_timeout_q
);
    logic [7:0]  setup1_q;
    logic [7:0]  setup2_q;
    logic [7:0]  config_q;
    logic [2:0]  page_q;
    logic [7:0]  refuse_cnt_q;
    logic [21:0] rcn_cnt_q;

    nsr_tick_if tk ();
    nsr_rate_div u_div (
        .clk (clk),
        .rst (rst),
        .tk  (tk)
    );

    wire       wr_page   = wr_stb && addr == nsr_pkg::ADDR_PAGE;
    wire       wr_cfg    = wr_stb && addr == nsr_pkg::ADDR_CONFIG;
    wire       wr_paged  = wr_stb && addr == nsr_pkg::ADDR_PAGED;
    wire       sel_s1    = page_q == nsr_pkg::PAGE_SETUP1;
    wire       sel_s2    = page_q == nsr_pkg::PAGE_SETUP2;
    wire       soft_rst  = config_q[nsr_pkg::CFG_SOFT_RST];
    wire [7:0] ref_limit = setup1_q[nsr_pkg::S1_SHORT_LIM] ?
                           nsr_pkg::REFUSE_SHORT : nsr_pkg::REFUSE_LONG;
    wire       ref_hit   = refusal_evt &&
                           (refuse_cnt_q + 8'h01 >= ref_limit);
    wire       ref_clear = refusal_clr || soft_rst;
    wire       own_dest  = pkt_dest_id == node_id;
    wire       promisc   = setup1_q[nsr_pkg::S1_PROMISC];
    wire [1:0] rcn_sel   = setup2_q[nsr_pkg::S2_RCN_LO +: 2];
    wire [21:0] rcn_limit =
        (rcn_sel == 2'h0) ? 22'(RCN0_BITS) :
        (rcn_sel == 2'h1) ? 22'(RCN1_BITS) :
        (rcn_sel == 2'h2) ? 22'(RCN2_BITS) : 22'(RCN3_BITS);
    wire       rcn_done  = tk.rate_tick && rcn_cnt_q >= rcn_limit - 22'h1;
    wire       pp_mode   = setup1_q[nsr_pkg::S1_PULSE_PP];
    wire [7:0] rd_mux    =
        (addr == nsr_pkg::ADDR_PAGE)   ? {5'h00, page_q} :
        (addr == nsr_pkg::ADDR_CONFIG) ? {config_q[7:2], page_q[1:0]} :
        (addr == nsr_pkg::ADDR_PAGED && sel_s1) ? setup1_q :
        (addr == nsr_pkg::ADDR_PAGED && sel_s2) ? setup2_q : 8'h00;

    assign tk.rate_sel = setup1_q[nsr_pkg::S1_CKP_LO +: 3];
    assign tk.half_arb = setup1_q[nsr_pkg::S1_HALF_ARB];

    // Setup registers only see the hard reset, so soft reset keeps them
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            setup1_q <= nsr_pkg::SETUP1_RST;
            setup2_q <= nsr_pkg::SETUP2_RST;
        end
        else if (wr_paged)
        begin
            if (sel_s1)
                setup1_q <= wdata;
            if (sel_s2)
                setup2_q <= wdata;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            config_q <= nsr_pkg::CONFIG_RST;
            page_q   <= nsr_pkg::PAGE_RST;
        end
        else if (wr_cfg)
        begin
            config_q <= wdata;
            page_q   <= {1'b0, wdata[1:0]};
        end
        else if (wr_page)
            page_q <= wdata[2:0];
    end

    // A refusal in the clearing cycle still counts, and a set beats a clear
    // so a limit reached while software clears is never lost
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            refuse_cnt_q          <= 8'h00;
            excess_refusal_flag_q <= 1'b0;
        end
        else
        begin
            if (ref_clear)
                refuse_cnt_q <= refusal_evt ? 8'h01 : 8'h00;
            else if (refusal_evt && !excess_refusal_flag_q)
                refuse_cnt_q <= refuse_cnt_q + 8'h01;
            if (ref_hit)
                excess_refusal_flag_q <= 1'b1;
            else if (ref_clear)
                excess_refusal_flag_q <= 1'b0;
        end
    end

    // Open drain pulls low while a pulse is requested
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pulse_out_q  <= 1'b0;
            pulse_oe_n_q <= 1'b1;
        end
        else
        begin
            pulse_out_q  <= pp_mode ? pulse_req : 1'b0;
            pulse_oe_n_q <= pp_mode ? 1'b0 : ~pulse_req;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rdata_q      <= 8'h00;
            pkt_accept_q <= 1'b0;
            pkt_ack_q    <= 1'b0;
            rate_tick_q  <= 1'b0;
            arb_tick_q   <= 1'b0;
            fast_read_q  <= 1'b0;
            enhanced_q   <= 1'b0;
            init_wr_ok_q <= 1'b0;
        end
        else
        begin
            rdata_q      <= rd_mux;
            pkt_accept_q <= pkt_valid && (promisc || own_dest);
            pkt_ack_q    <= pkt_valid && own_dest;
            rate_tick_q  <= tk.rate_tick;
            arb_tick_q   <= tk.arb_tick;
            fast_read_q  <= setup2_q[nsr_pkg::S2_FAST_READ];
            enhanced_q   <= setup2_q[nsr_pkg::S2_ENHANCED];
            init_wr_ok_q <= init_wr_req &&
                (setup2_q[nsr_pkg::S2_IDLE_OFF] || line_idle);
        end
    end

    // Timer counts bit periods, so a slower rate stretches the timeout
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rcn_cnt_q          <= 22'h0;
            reconfig_timeout_q <= 1'b0;
        end
        else
        begin
            reconfig_timeout_q <= rcn_done && !reconfig_restart;
            if (reconfig_restart || rcn_done)
                rcn_cnt_q <= 22'h0;
            else if (tk.rate_tick)
                rcn_cnt_q <= rcn_cnt_q + 22'h1;
        end
    end

    sequence seq_cfg_write;
        wr_cfg;
    endsequence
    sequence seq_page_cleared;
        !page_q[nsr_pkg::PAGE_TOP];
    endsequence

    chk_pulse_drive: assert property (@(posedge clk) disable iff (rst)
        (pp_mode && !$past(rst)) |=> !pulse_oe_n_q)
        else $error("push-pull mode not driving");
    chk_refusal_limit: assert property (@(posedge clk) disable iff (rst)
        $rose(excess_refusal_flag_q) |->
        $past(refuse_cnt_q) == $past(ref_limit) - 8'h01)
        else $error("refusal flag at wrong count");
    chk_accept_any: assert property (@(posedge clk) disable iff (rst)
        (pkt_valid && promisc) |=> pkt_accept_q)
        else $error("promiscuous packet not accepted");
    chk_ack_own: assert property (@(posedge clk) disable iff (rst)
        pkt_ack_q |-> $past(own_dest) && $past(pkt_valid))
        else $error("acknowledge for foreign destination");
    chk_fast_read: assert property (@(posedge clk) disable iff (rst)
        fast_read_q == $past(setup2_q[nsr_pkg::S2_FAST_READ]))
        else $error("fast read timing mismatch");
    chk_idle_wait: assert property (@(posedge clk) disable iff (rst)
        init_wr_ok_q |->
        $past(line_idle) || $past(setup2_q[nsr_pkg::S2_IDLE_OFF]))
        else $error("init write allowed on busy line");
    chk_page_clear: assert property (@(posedge clk) disable iff (rst)
        seq_cfg_write |=> seq_page_cleared)
        else $error("top page bit survived config write");
    chk_soft_keep: assert property (@(posedge clk) disable iff (rst)
        (soft_rst && !wr_paged) |=> $stable(setup1_q))
        else $error("setup changed by soft reset");
    chk_setup_read: assert property (@(posedge clk) disable iff (rst)
        (wr_paged && sel_s1) ##1 (addr == nsr_pkg::ADDR_PAGED && sel_s1
        && !wr_stb) |=> rdata_q == $past(wdata, 2))
        else $error("setup read differs from write");
endmodule
`default_nettype wire

// ===== test/nsr_host_model.sv
// Host microcontroller model driving the parallel register port
`timescale 1ns/1ps
`default_nettype none
module nsr_host_model
(
    // Clock
    input  wire logic       clk,
    // Register port
    output logic      [2:0] addr,
    output logic      [7:0] wdata,
    output logic            wr_stb,
    input  wire logic [7:0] rdata_q
);
    initial
    begin
        addr = 3'h0;
        wdata = 8'h00;
        wr_stb = 1'b0;
    end
    // Plain non-multiplexed cycles only, so fast reads are always legal
    // Rates used stay far below the level that demands enhanced mode
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
        // Data is no longer qualified, so it must not look still valid
        wdata <= ~d;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        repeat (2) @(posedge clk);
        #1;
        v = rdata_q;
    endtask
endmodule
`default_nettype wire

// ===== test/network_setup_registers_tb.sv
// Self-checking bench for the network setup register bank
`timescale 1ns/1ps
`default_nettype none
module network_setup_registers_tb;
    logic        clk, rst, pulse_req, refusal_evt, refusal_clr, pkt_valid;
    logic        line_idle, init_wr_req, reconfig_restart, wr_stb;
    logic        pulse_out_q, pulse_oe_n_q, excess_refusal_flag_q;
    logic        pkt_accept_q, pkt_ack_q, rate_tick_q, arb_tick_q;
    logic        fast_read_q, enhanced_q, init_wr_ok_q, reconfig_timeout_q;
    logic [2:0]  addr;
    logic [7:0]  wdata, rdata_q, pkt_dest_id, node_id, rv, m_s1, m_s2;
    logic [31:0] seed, r;
    int          num_errors, total_checks, cyc, n, lo, hi;
    int          rcn[4] = '{40, 20, 10, 5};

    nsr_host_model host (.clk(clk), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rdata_q(rdata_q));
    // Short timeout counts keep the run brief
    nsr_setup_regs #(.RCN0_BITS(40), .RCN1_BITS(20), .RCN2_BITS(10),
        .RCN3_BITS(5)) dut (
        .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
        .rdata_q(rdata_q), .pulse_req(pulse_req), .pulse_out_q(pulse_out_q),
        .pulse_oe_n_q(pulse_oe_n_q), .refusal_evt(refusal_evt),
        .refusal_clr(refusal_clr),
        .excess_refusal_flag_q(excess_refusal_flag_q),
        .pkt_valid(pkt_valid), .pkt_dest_id(pkt_dest_id), .node_id(node_id),
        .pkt_accept_q(pkt_accept_q), .pkt_ack_q(pkt_ack_q),
        .rate_tick_q(rate_tick_q), .arb_tick_q(arb_tick_q),
        .fast_read_q(fast_read_q), .enhanced_q(enhanced_q),
        .line_idle(line_idle), .init_wr_req(init_wr_req),
        .init_wr_ok_q(init_wr_ok_q), .reconfig_restart(reconfig_restart),
        .reconfig_timeout_q(reconfig_timeout_q));

    initial clk = 1'b0;
    always #25 clk = ~clk;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic set1(input logic [7:0] v);
        host.wr(3'h5, 8'h02);
        host.wr(3'h7, v);
        m_s1 = v;
    endtask
    task automatic set2(input logic [7:0] v);
        host.wr(3'h5, 8'h04);
        host.wr(3'h7, v);
        m_s2 = v;
    endtask
    task automatic rdp(input logic [2:0] p, input logic [7:0] e);
        host.wr(3'h5, {5'h00, p});
        host.rd(3'h7, rv);
        chk(rv, e);
    endtask
    task automatic refuse(input int k);
        repeat (k)
        begin
            @(posedge clk) refusal_evt <= 1'b1;
            @(posedge clk) refusal_evt <= 1'b0;
        end
    endtask
    // First tick may follow a divisor change mid-count, so skip it
    task automatic gap(output int g);
        g = 0;
        while (rate_tick_q !== 1'b1 && g < 300) @(negedge clk) g++;
        g = 0;
        do @(negedge clk) g++; while (rate_tick_q !== 1'b1 && g < 300);
    endtask

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            num_errors++;
            complete_run();
        end
    end

    initial
    begin
        seed = 32'h4672D312;
        num_errors = 0;
        total_checks = 0;
        rst = 1'b1;
        {pulse_req, refusal_evt, refusal_clr, pkt_valid} = 4'h0;
        {line_idle, init_wr_req, reconfig_restart} = 3'h0;
        pkt_dest_id = 8'h00;
        node_id = 8'h00;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk({pulse_oe_n_q, pulse_out_q}, 2'b10);
        chk(excess_refusal_flag_q, 0);
        chk(fast_read_q, 0);
        chk(enhanced_q, 0);
        rdp(3'h2, 8'h00);
        rdp(3'h4, 8'h00);
        r = rnd();
        set1(r[7:0] & 8'hDF);
        set2(r[15:8]);
        host.wr(3'h5, 8'h01);
        host.wr(3'h7, 8'hFF);
        for (int p = 0; p < 8; p++)
            rdp(p[2:0], p == 2 ? m_s1 : (p == 4 ? m_s2 : 8'h00));
        host.wr(3'h5, 8'h04);
        host.wr(3'h6, 8'h02);
        host.rd(3'h7, rv);
        chk(rv, m_s1);
        host.rd(3'h5, rv);
        chk(rv, 8'h02);
        for (int i = 0; i < 4; i++)
        begin
            set2({i[1], 3'h0, i[0], 3'h0});
            settle();
            chk(fast_read_q, i[1]);
            chk(enhanced_q, i[0]);
        end
        for (int i = 0; i < 4; i++)
        begin
            set1({i[1], 7'h00});
            pulse_req <= i[0];
            settle();
            chk(pulse_out_q, i[1] && i[0]);
            chk(pulse_oe_n_q, !i[1] && !i[0]);
        end
        for (int i = 0; i < 24; i++)
        begin
            if (i % 12 == 0)
                set1({3'h0, i == 12, 4'h0});
            r = rnd();
            @(posedge clk);
            node_id <= r[7:0];
            pkt_dest_id <= r[8] ? r[7:0] : r[15:8];
            pkt_valid <= 1'b1;
            @(posedge clk) pkt_valid <= 1'b0;
            #1;
            chk(pkt_ack_q, pkt_dest_id == node_id);
            chk(pkt_accept_q, i >= 12 || pkt_dest_id == node_id);
        end
        for (int i = 0; i < 2; i++)
        begin
            set1(i ? 8'h00 : 8'h40);
            @(posedge clk) refusal_clr <= 1'b1;
            @(posedge clk) refusal_clr <= 1'b0;
            refuse(i ? 127 : 3);
            settle();
            chk(excess_refusal_flag_q, 0);
            refuse(1);
            settle();
            chk(excess_refusal_flag_q, 1);
        end
        // Limit reached in the very cycle of a clear: the flag must still set
        set1(8'h40);
        @(posedge clk) refusal_clr <= 1'b1;
        @(posedge clk) refusal_clr <= 1'b0;
        refuse(3);
        @(posedge clk)
        begin
            refusal_evt <= 1'b1;
            refusal_clr <= 1'b1;
        end
        @(posedge clk)
        begin
            refusal_evt <= 1'b0;
            refusal_clr <= 1'b0;
        end
        settle();
        chk(excess_refusal_flag_q, 1);
        host.wr(3'h6, 8'h80);
        host.wr(3'h6, 8'h02);
        settle();
        chk(excess_refusal_flag_q, 0);
        rdp(3'h2, m_s1);
        rdp(3'h4, m_s2);
        for (int i = 0; i < 4; i++)
        begin
            set2({5'h00, i[1], 2'h0});
            @(posedge clk);
            line_idle <= i[0];
            init_wr_req <= 1'b1;
            @(posedge clk) init_wr_req <= 1'b0;
            #1;
            chk(init_wr_ok_q, i[1] || i[0]);
        end
        for (int c = 0; c < 8; c++)
        begin
            set1({4'h0, c[2:0], c[0]});
            settle();
            gap(n);
            chk(n, c == 0 ? 64 : 128);
            @(negedge clk) rv[0] = arb_tick_q;
            @(negedge clk) rv[1] = arb_tick_q;
            chk(c[0] ? rv[0] ^ rv[1] : rv[0] & rv[1], 1);
        end
        set1(8'h00);
        // Rising limits, so a stale count never meets the new limit
        for (int c = 3; c >= 0; c--)
        begin
            set2({6'h00, c[1:0]});
            @(posedge clk) reconfig_restart <= 1'b1;
            @(posedge clk) reconfig_restart <= 1'b0;
            #1;
            lo = (rcn[c] - 1) * 64;
            hi = rcn[c] * 64 + 4;
            n = 0;
            while (reconfig_timeout_q !== 1'b1 && n < hi + 8)
                @(negedge clk) n++;
            chk(n >= lo && n <= hi, 1);
        end
        complete_run();
    end
endmodule
`default_nettype wire
